// file: include/irq_logic_regs.vh
// register map, field positions and codes for the interrupt request logic
// assumes an 8-bit register port driven by the host interface decoder
`ifndef IRQ_LOGIC_REGS_VH
`define IRQ_LOGIC_REGS_VH

`define ADDR_W             8
`define ADDR_FLAG_REG_A    8'h06
`define ADDR_FLAG_REG_B    8'h07
`define ADDR_ENABLE_REG_A  8'h08
`define ADDR_ENABLE_REG_B  8'h09

`define SET_BIT            7
`define FLAG_A_W           7
`define FLAG_B_W           6
`define FLAGS_RESET_A      7'h00
`define FLAGS_RESET_B      6'h00
`define ENABLE_RESET       8'h00

`define BIT_FIFO_HIGH      6
`define BIT_FIFO_LOW       5
`define BIT_CMD_DONE       4
`define BIT_TX_DONE        3
`define BIT_RX_DONE        2
`define BIT_ERROR          1
`define BIT_FRAME_START    0

`define BIT_GLOBAL         6
`define BIT_CARD_DETECT    5
`define TIMER_COUNT        5

`define BIT_PIN_INVERT     7
`define BIT_PIN_ENABLE     6
`define BIT_PIN_PUSH_PULL  7

`define CMD_W              5
`define CMD_IDLE           5'h00
`define CMD_VALID_MASK     32'h0000_ffff

`endif

// file: src/flag_bank.v
// one bank of latched interrupt flags with set/clear-qualified writes
// assumes source events are one-cycle or level signals synchronous to sys_clk_i
`include "irq_logic_regs.vh"

module flag_bank #(
  parameter WIDTH = 7
) (
  // clock and reset
  input  wire             sys_clk_i,
  input  wire             rst_i,
  // host write
  input  wire             wr_i,
  input  wire [7:0]       wdata_i,
  // hardware events
  input  wire [WIDTH-1:0] event_i,
  // latched flags
  output reg  [WIDTH-1:0] flags_o
);

  wire             set_mode;
  wire [WIDTH-1:0] sel;
  reg  [WIDTH-1:0] flags_next;

  assign set_mode = wdata_i[`SET_BIT];
  assign sel      = wr_i ? wdata_i[WIDTH-1:0] : {WIDTH{1'b0}};

  // events are ORed in last so an event in a clear cycle is kept
  always @*
  begin
    flags_next = flags_o;
    if (set_mode)
    begin
      flags_next = flags_o | sel;
    end
    else
    begin
      flags_next = flags_o & ~sel;
    end
    flags_next = flags_next | event_i;
  end

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      flags_o <= {WIDTH{1'b0}};
    end
    else
    begin
      flags_o <= flags_next;
    end
  end

endmodule

// file: src/rise_detect.v
// rising-edge detector for live status levels
// assumes levels are synchronous to sys_clk_i
module rise_detect #(
  parameter WIDTH = 2
) (
  // clock and reset
  input  wire             sys_clk_i,
  input  wire             rst_i,
  // levels in, one-cycle rise pulses out
  input  wire [WIDTH-1:0] level_i,
  output wire [WIDTH-1:0] rise_o
);

  reg [WIDTH-1:0] level_reg;

  assign rise_o = level_i & ~level_reg;

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      // track the level in reset so a level already high is no false edge
      level_reg <= level_i;
    end
    else
    begin
      level_reg <= level_i;
    end
  end

endmodule

// file: src/irq_logic.v
// interrupt request logic of a contactless reader frontend: two latched flag
// registers, two enable registers, global interrupt and interrupt pin drive
// assumes the host interface decoder presents one-cycle read/write strobes
// with an 8-bit address, and that all sources are synchronous to sys_clk_i
`include "irq_logic_regs.vh"

module irq_logic (
  // clock and reset
  input  wire                  sys_clk_i,
  input  wire                  rst_i,
  // register port from host interface
  input  wire                  reg_wr_i,
  input  wire                  reg_rd_i,
  input  wire [`ADDR_W-1:0]    reg_addr_i,
  input  wire [7:0]            reg_wdata_i,
  output reg  [7:0]            reg_rdata_o,
  output wire                  reg_hit_o,
  // command field
  input  wire                  cmd_wr_i,
  input  wire [`CMD_W-1:0]     cmd_wdata_i,
  input  wire                  cmd_end_i,
  output reg  [`CMD_W-1:0]     cmd_o,
  // fifo status levels
  input  wire                  fifo_high_live_i,
  input  wire                  fifo_low_live_i,
  // transceiver events
  input  wire                  tx_last_bit_i,
  input  wire                  rx_end_i,
  input  wire                  rx_frame_start_i,
  // error sources
  input  wire                  fifo_write_error_i,
  input  wire                  fifo_overflow_error_i,
  input  wire                  protocol_error_i,
  input  wire                  no_data_error_i,
  input  wire                  integrity_error_i,
  // card detection and timers
  input  wire                  card_detected_i,
  input  wire [`TIMER_COUNT-1:0] timer_underflow_i,
  // interrupt pin
  output reg                   irq_pin_o,
  output reg                   irq_pin_oe_o,
  output wire                  any_enabled_flag_o
);

  localparam ST_IDLE = 2'b01;
  localparam ST_RUN  = 2'b10;

  reg  [1:0]               cmd_state_reg;
  reg  [1:0]               cmd_state_next;
  reg  [`CMD_W-1:0]        cmd_next;
  reg                      cmd_done_pulse;

  reg  [7:0]               enable_reg_a;
  reg  [7:0]               enable_reg_b;

  wire [`FLAG_A_W-1:0]     flag_reg_a;
  wire [`FLAG_B_W-1:0]     flag_reg_b;
  wire [`FLAG_A_W-1:0]     events_a;
  wire [`FLAG_B_W-1:0]     events_b;
  wire [1:0]               alert_rise;
  wire [4:0]               error_now;
  wire [4:0]               error_rise;
  wire                     wr_a;
  wire                     wr_b;
  wire                     pin_level;

  // codes outside the supported set behave as an unknown command
  function known_cmd;
    input [`CMD_W-1:0] code;
    reg   [31:0]       mask;
    begin
      mask      = `CMD_VALID_MASK;
      known_cmd = mask[code];
    end
  endfunction

  function addr_is;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] b;
    begin
      addr_is = (a == b);
    end
  endfunction

  rise_detect #(
    .WIDTH (2)
  ) u_alert_rise (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .level_i   ({fifo_high_live_i, fifo_low_live_i}),
    .rise_o    (alert_rise)
  );

  // error bits are levels in the error register; only a new error flags
  rise_detect #(
    .WIDTH (5)
  ) u_error_rise (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .level_i   ({fifo_write_error_i, fifo_overflow_error_i, protocol_error_i,
                 no_data_error_i, integrity_error_i}),
    .rise_o    (error_rise)
  );

  assign error_now = error_rise;

  // command tracking
  always @*
  begin
    cmd_next       = cmd_o;
    cmd_state_next = cmd_state_reg;
    cmd_done_pulse = 1'b0;
    case (cmd_state_reg)
      ST_IDLE:
      begin
        if (cmd_wr_i && (cmd_wdata_i != `CMD_IDLE))
        begin
          if (known_cmd(cmd_wdata_i))
          begin
            cmd_next       = cmd_wdata_i;
            cmd_state_next = ST_RUN;
          end
          else
          begin
            cmd_next       = `CMD_IDLE;
            cmd_done_pulse = 1'b1;
          end
        end
      end
      ST_RUN:
      begin
        if (cmd_wr_i && (cmd_wdata_i == `CMD_IDLE))
        begin
          cmd_next       = `CMD_IDLE;
          cmd_state_next = ST_IDLE;
        end
        else if (cmd_wr_i && !known_cmd(cmd_wdata_i))
        begin
          cmd_next       = `CMD_IDLE;
          cmd_state_next = ST_IDLE;
          cmd_done_pulse = 1'b1;
        end
        else if (cmd_wr_i)
        begin
          cmd_next = cmd_wdata_i;
        end
        else if (cmd_end_i)
        begin
          cmd_next       = `CMD_IDLE;
          cmd_state_next = ST_IDLE;
          cmd_done_pulse = 1'b1;
        end
      end
      default:
      begin
        cmd_next       = `CMD_IDLE;
        cmd_state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      cmd_o         <= `CMD_IDLE;
      cmd_state_reg <= ST_IDLE;
    end
    else
    begin
      cmd_o         <= cmd_next;
      cmd_state_reg <= cmd_state_next;
    end
  end

  assign events_a[`BIT_FIFO_HIGH]   = alert_rise[1];
  assign events_a[`BIT_FIFO_LOW]    = alert_rise[0];
  assign events_a[`BIT_CMD_DONE]    = cmd_done_pulse;
  assign events_a[`BIT_TX_DONE]     = tx_last_bit_i;
  assign events_a[`BIT_RX_DONE]     = rx_end_i;
  assign events_a[`BIT_ERROR]       = |error_now;
  assign events_a[`BIT_FRAME_START] = rx_frame_start_i;

  assign events_b[`BIT_CARD_DETECT] = card_detected_i;
  assign events_b[`TIMER_COUNT-1:0] = timer_underflow_i;

  assign wr_a = reg_wr_i && addr_is(reg_addr_i, `ADDR_FLAG_REG_A);
  assign wr_b = reg_wr_i && addr_is(reg_addr_i, `ADDR_FLAG_REG_B);

  flag_bank #(
    .WIDTH (`FLAG_A_W)
  ) u_bank_a (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_a),
    .wdata_i   (reg_wdata_i),
    .event_i   (events_a),
    .flags_o   (flag_reg_a)
  );

  flag_bank #(
    .WIDTH (`FLAG_B_W)
  ) u_bank_b (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_b),
    .wdata_i   (reg_wdata_i),
    .event_i   (events_b),
    .flags_o   (flag_reg_b)
  );

  // enable registers
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      enable_reg_a <= `ENABLE_RESET;
      enable_reg_b <= `ENABLE_RESET;
    end
    else if (reg_wr_i)
    begin
      if (addr_is(reg_addr_i, `ADDR_ENABLE_REG_A))
      begin
        enable_reg_a <= reg_wdata_i;
      end
      if (addr_is(reg_addr_i, `ADDR_ENABLE_REG_B))
      begin
        enable_reg_b <= reg_wdata_i;
      end
    end
  end

  // combinational so it falls as soon as the last enabled flag goes
  assign any_enabled_flag_o =
    (|(flag_reg_a & enable_reg_a[`FLAG_A_W-1:0])) |
    (|(flag_reg_b & enable_reg_b[`FLAG_B_W-1:0]));

  assign pin_level = (any_enabled_flag_o & enable_reg_b[`BIT_PIN_ENABLE])
                     ^ enable_reg_a[`BIT_PIN_INVERT];

  // open drain only ever pulls low, so an active-low level drives when 0
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      irq_pin_o    <= 1'b0;
      irq_pin_oe_o <= 1'b0;
    end
    else
    begin
      irq_pin_o    <= pin_level;
      if (enable_reg_b[`BIT_PIN_PUSH_PULL])
      begin
        irq_pin_oe_o <= 1'b1;
      end
      else
      begin
        irq_pin_oe_o <= ~pin_level;
      end
    end
  end

  // read path: set qualifier bits read as zero
  assign reg_hit_o = addr_is(reg_addr_i, `ADDR_FLAG_REG_A) |
                     addr_is(reg_addr_i, `ADDR_FLAG_REG_B) |
                     addr_is(reg_addr_i, `ADDR_ENABLE_REG_A) |
                     addr_is(reg_addr_i, `ADDR_ENABLE_REG_B);

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `ADDR_FLAG_REG_A:   reg_rdata_o <= {1'b0, flag_reg_a};
        `ADDR_FLAG_REG_B:   reg_rdata_o <= {1'b0, any_enabled_flag_o, flag_reg_b};
        `ADDR_ENABLE_REG_A: reg_rdata_o <= enable_reg_a;
        `ADDR_ENABLE_REG_B: reg_rdata_o <= enable_reg_b;
        default:            reg_rdata_o <= 8'h00;
      endcase
    end
  end

endmodule

// file: verification/irq_host_model.sv
// host side of the interrupt pin: resolves the line seen by the controller
// assumes an external pull-up on the line, as an open-drain pin needs
module irq_host_model (
  // pin drive from the device
  input  wire logic pin_i,
  input  wire logic oe_i,
  // resolved line level
  output wire logic line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released pin floats up to the pull-up level, never holds its last value
  assign line_o = oe_i ? pin_i : 1'b1;
endmodule

// file: verification/irq_logic_properties.sv
// port-level checks for the interrupt request logic
// assumes it is bound to irq_logic and sees only its ports
module irq_logic_properties (
  // clock and reset
  input wire logic       sys_clk_i,
  input wire logic       rst_i,
  // register writes and command field
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       cmd_wr_i,
  input wire logic [4:0] cmd_wdata_i,
  input wire logic       cmd_end_i,
  input wire logic [4:0] cmd_o,
  // events and outputs
  input wire logic       card_detected_i,
  input wire logic [4:0] timer_underflow_i,
  input wire logic       irq_pin_o,
  input wire logic       irq_pin_oe_o,
  input wire logic       any_enabled_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // shadow enables: the enables are not visible at the ports
  logic [7:0] en_a_reg;
  logic [7:0] en_b_reg;
  wire        pin_calc = (any_enabled_flag_o & en_b_reg[6]) ^ en_a_reg[7];
  always @(posedge sys_clk_i)
    if (rst_i)
    begin
      en_a_reg <= 8'h00;
      en_b_reg <= 8'h00;
    end
    else if (reg_wr_i && reg_addr_i == 8'h08)
      en_a_reg <= reg_wdata_i;
    else if (reg_wr_i && reg_addr_i == 8'h09)
      en_b_reg <= reg_wdata_i;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_pin_follows: assert property (!$past(rst_i) |-> irq_pin_o == $past(pin_calc))
    else $error("pin does not follow gated global");
  a_pin_drive_mode: assert property (!$past(rst_i) && !irq_pin_oe_o |-> irq_pin_o)
    else $error("pin released while low");
  a_push_pull: assert property (!$past(rst_i) && $past(en_b_reg[7]) |-> irq_pin_oe_o)
    else $error("push-pull pin not driven");
  a_timer_global: assert property (!reg_wr_i && |(timer_underflow_i & en_b_reg[4:0])
    |=> any_enabled_flag_o)
    else $error("timer flag missing from global");
  a_card_global: assert property (!reg_wr_i && card_detected_i && en_b_reg[5]
    |=> any_enabled_flag_o)
    else $error("card flag missing from global");
  a_no_enable_quiet: assert property (en_a_reg[6:0] == 7'h00 && en_b_reg[5:0] == 6'h00
    |-> !any_enabled_flag_o)
    else $error("global set with all enables off");
  a_flag_sticky: assert property (any_enabled_flag_o && !reg_wr_i |=> any_enabled_flag_o)
    else $error("global dropped without a write");
  a_cmd_done: assert property (cmd_end_i && cmd_o != 5'h00 && en_a_reg[4] && !reg_wr_i
    && !cmd_wr_i |=> any_enabled_flag_o && cmd_o == 5'h00)
    else $error("command end not reported");
  a_unknown_cmd: assert property (cmd_wr_i && cmd_wdata_i[4] |=> cmd_o == 5'h00)
    else $error("unknown command not returned to idle");
  a_host_idle: assert property (cmd_wr_i && cmd_wdata_i == 5'h00 && en_a_reg == 8'h10
    && en_b_reg[5:0] == 6'h00 && !any_enabled_flag_o && !cmd_end_i && !reg_wr_i
    |=> !any_enabled_flag_o)
    else $error("host idle write set command done");
endmodule

bind irq_logic irq_logic_properties u_irq_logic_properties (.sys_clk_i, .rst_i, .reg_wr_i,
  .reg_addr_i, .reg_wdata_i, .cmd_wr_i, .cmd_wdata_i, .cmd_end_i, .cmd_o, .card_detected_i,
  .timer_underflow_i, .irq_pin_o, .irq_pin_oe_o, .any_enabled_flag_o);

// file: verification/tb_top.sv
// self-checking bench for the interrupt request logic
// assumes the host model resolves the pin; all sources are driven here
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, cmd_wr_i = 0;
  logic [7:0]  reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, r, c, m, ad;
  logic [4:0]  cmd_wdata_i = 0, cmd_o;
  logic [17:0] src = 0;
  logic        irq_pin_o, irq_pin_oe_o, any_enabled_flag_o, irq_line, rd_pend = 0, reg_hit_o;
  logic [7:0]  exp_q[$];
  int          error_cnt = 0, n_compared = 0;
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  irq_logic u_irq_logic (.sys_clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .reg_hit_o, .cmd_wr_i, .cmd_wdata_i, .cmd_end_i(src[17]), .cmd_o,
    .fifo_high_live_i(src[6]), .fifo_low_live_i(src[5]), .tx_last_bit_i(src[3]),
    .rx_end_i(src[2]), .rx_frame_start_i(src[0]), .fifo_write_error_i(src[1]),
    .fifo_overflow_error_i(src[7]), .protocol_error_i(src[8]), .no_data_error_i(src[9]),
    .integrity_error_i(src[10]), .card_detected_i(src[16]), .timer_underflow_i(src[15:11]),
    .irq_pin_o, .irq_pin_oe_o, .any_enabled_flag_o);
  irq_host_model u_irq_host_model (.pin_i(irq_pin_o), .oe_i(irq_pin_oe_o), .line_o(irq_line));
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one access per call; a read notes its expected data for the monitor
  task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
    @(negedge sys_clk_i);
    reg_wr_i = w;
    reg_rd_i = !w;
    reg_addr_i = a;
    reg_wdata_i = d;
    if (!w) exp_q.push_back(d);
    #1 check("reg_hit_o", {7'h00, reg_hit_o}, {7'h00, a > 8'h05 && a < 8'h0a});
    @(negedge sys_clk_i);
    reg_wr_i = 0;
    reg_rd_i = 0;
  endtask
  task automatic pulse(int i);
    @(negedge sys_clk_i);
    src[i] = 1;
    @(negedge sys_clk_i);
    src[i] = 0;
  endtask
  task automatic cmd(logic [4:0] code);
    @(negedge sys_clk_i);
    cmd_wr_i = 1;
    cmd_wdata_i = code;
    @(negedge sys_clk_i);
    cmd_wr_i = 0;
  endtask
  // read data is registered, so it is compared half a cycle after the taking edge
  always @(posedge sys_clk_i) rd_pend <= reg_rd_i;
  always @(negedge sys_clk_i)
    if (rd_pend)
      check("reg_rdata_o", reg_rdata_o, exp_q.pop_front());
  initial
  begin
    r = $urandom(32'h6489);
    repeat (12) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_i = 0;
    for (int a = 6; a < 11; a++)
      bus(0, a[7:0], 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      r = $urandom;
      bus(1, 8'h08, r);
      bus(0, 8'h08, r);
      bus(1, 8'h09, ~r);
      bus(0, 8'h09, ~r);
    end
    bus(1, 8'h08, 8'h00);
    bus(1, 8'h09, 8'h00);
    for (int k = 0; k < 6; k++)
    begin
      r = $urandom;
      c = $urandom;
      ad = 8'h06 + 8'(k % 2);
      m = (k % 2) ? 8'h3f : 8'h7f;
      bus(1, ad, r | 8'h80);
      bus(1, ad, c & 8'h7f);
      bus(0, ad, r & ~c & m);
      bus(1, ad, 8'h7f);
    end
    bus(1, 8'h08, 8'h7f);
    bus(1, 8'h09, 8'h3f);
    for (int i = 0; i < 17; i++)
    begin
      if (i == 4) continue;
      ad = (i > 10) ? 8'h07 : 8'h06;
      m = (i > 15) ? 8'h20 : (i > 10) ? 8'h01 << (i - 11) : (i > 6) ? 8'h02 : 8'h01 << i;
      pulse(i);
      bus(1, ad, 8'h80);
      bus(0, ad, m | ((i > 10) ? 8'h40 : 8'h00));
      bus(1, ad, m);
      bus(0, ad, 8'h00);
    end
    bus(1, 8'h08, 8'h10);
    bus(1, 8'h09, 8'h00);
    cmd(5'h03);
    pulse(17);
    check("cmd_o", {3'h0, cmd_o}, 8'h00);
    bus(0, 8'h06, 8'h10);
    bus(1, 8'h06, 8'h10);
    cmd(5'h03);
    check("cmd_o", {3'h0, cmd_o}, 8'h03);
    cmd(5'h00);
    check("cmd_o", {3'h0, cmd_o}, 8'h00);
    bus(0, 8'h06, 8'h00);
    cmd(5'h1f);
    check("cmd_o", {3'h0, cmd_o}, 8'h00);
    bus(0, 8'h06, 8'h10);
    bus(1, 8'h06, 8'h10);
    cmd(5'h05);
    cmd(5'h15);
    check("cmd_o", {3'h0, cmd_o}, 8'h00);
    bus(0, 8'h06, 8'h10);
    for (int k = 0; k < 8; k++)
    begin
      bus(1, 8'h08, {k[0], 7'h10});
      bus(1, 8'h09, {k[2:1], 6'h00});
      @(negedge sys_clk_i);
      m = {7'h00, k[1] ^ k[0]};
      check("irq_line", {7'h00, irq_line}, m);
      check("irq_pin_o", {7'h00, irq_pin_o}, m);
      check("any_enabled_flag_o", {7'h00, any_enabled_flag_o}, 8'h01);
      check("irq_pin_oe_o", {7'h00, irq_pin_oe_o}, {7'h00, k[2] | ~m[0]});
      bus(0, 8'h07, 8'h40);
    end
    bus(1, 8'h06, 8'h10);
    bus(0, 8'h07, 8'h00);
    results;
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk_i);
    error_cnt++;
    results;
  end
endmodule
